// >>> hw/tmz_defines.svh
// register map, field positions, reset values and divider constants of the timer
// assumes: included by bare name from the design files of this block
`ifndef TMZ_DEFINES_SVH
`define TMZ_DEFINES_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define TMZ_IDX_W 8
`define TMZ_IDX_CLOCK_WAKE 8'hD8
`define TMZ_IDX_MODE 8'hDA
`define TMZ_IDX_COUNT 8'hDB
`define TMZ_IDX_RELOAD 8'hCD
`define TMZ_IDX_STATUS 8'hDC

// ***************************************************************
// mode register fields
// ***************************************************************
`define TMZ_MODE_PWM 0
`define TMZ_MODE_BUZ 1
`define TMZ_MODE_ALOAD 2
`define TMZ_MODE_SRC 3
`define TMZ_MODE_RATE_LO 4
`define TMZ_MODE_RATE_HI 6
`define TMZ_MODE_RUN 7
`define TMZ_MODE_RESET 8'h00

// ***************************************************************
// clock/wake register and status fields
// ***************************************************************
`define TMZ_CW_GREEN 1
`define TMZ_CW_FAST 2
`define TMZ_CW_OTHER 3
`define TMZ_CW_RESET 8'h00
`define TMZ_ST_OVF 0
`define TMZ_ST_PIN_IRQ 1
`define TMZ_COUNT_RESET 8'h00
`define TMZ_RELOAD_RESET 8'h00

// ***************************************************************
// overflow boundary masks
// ***************************************************************
`define TMZ_MASK_256 8'hFF
`define TMZ_MASK_64 8'h3F
`define TMZ_MASK_32 8'h1F
`define TMZ_MASK_16 8'h0F

// ***************************************************************
// prescaler: divisors in oscillator clocks at rate code 000
// ***************************************************************
`define TMZ_PRE_W 10
`define TMZ_PRE_FAST_MASK 10'h07F
`define TMZ_PRE_SLOW_MASK 10'h3FF

`endif

// >>> hw/tmz_event_sync.sv
// external event pin stage: synchroniser and falling-edge detector
// assumes: the pin is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module tmz_event_sync
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    tmz_tick_if.evt evt
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic agree;

    // a change counts only once the second and third stages agree
    assign agree = (s2_q == s3_q);

    // first stage feeds only the second; reset level high so no false edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            evt.event_level <= 1'b1;
            evt.event_fall <= 1'b0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
            begin
                evt.event_level <= s3_q;
            end
            evt.event_fall <= agree && evt.event_level && !s3_q;
        end
    end
endmodule
`default_nettype wire

// >>> hw/tmz_pkg.sv
// shared types of the timer block
// assumes: compiled before every other file of the block
package tmz_pkg;
    typedef logic [7:0] tmz_byte_t;
    typedef logic [2:0] tmz_rate_t;
endpackage

// >>> hw/tmz_prescaler.sv
// internal count-tick generator: oscillator or instruction clock through the rate divider
// assumes: clk_i is the oscillator clock; the instruction clock is it divided by eight
`timescale 1ns/1ps
`default_nettype none
`include "tmz_defines.svh"
module tmz_prescaler
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    tmz_tick_if.presc tick
);
    logic [`TMZ_PRE_W-1:0] div_q;
    logic [`TMZ_PRE_W-1:0] div_d;
    logic [`TMZ_PRE_W-1:0] base_mask;
    logic [`TMZ_PRE_W-1:0] sel_mask;
    logic tick_d;

    // divisor halves with each rate step; the fast clock runs eight times quicker
    assign base_mask = tick.fast_sel ? `TMZ_PRE_FAST_MASK : `TMZ_PRE_SLOW_MASK;
    assign sel_mask = base_mask >> tick.rate;
    assign div_d = div_q + 10'h001;
    assign tick_d = ((div_q & sel_mask) == sel_mask);

    // free-running divider; tick is one oscillator cycle wide
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            div_q <= '0;
            tick.int_tick <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick.int_tick <= tick_d;
        end
    end
endmodule
`default_nettype wire

// >>> hw/tmz_tick_if.sv
// count-tick carrier between the timer core, its prescaler and its event input stage
// assumes: one clock domain, all signals driven from flip-flops of the owning module
`timescale 1ns/1ps
`default_nettype none
interface tmz_tick_if;
    logic fast_sel;
    tmz_pkg::tmz_rate_t rate;
    logic int_tick;
    logic event_fall;
    logic event_level;
    modport presc (input fast_sel, input rate, output int_tick);
    modport evt (output event_fall, output event_level);
    modport core (output fast_sel, output rate, input int_tick, input event_fall, input event_level);
endinterface
`default_nettype wire

// >>> hw/tmz_timer0.sv
// timer 0: 8-bit up counter with prescaler, event counting, reload, buzzer and pwm
// assumes: apb slave with 32-bit data, clk_i is the oscillator clock, sync active-low reset
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tmz_defines.svh"

// Behaviour
// - mode bit0 routes pwm onto pin
// - mode bit1 buzzer toggles pin per overflow, boundary select in pwm
// - mode bit2 auto-reload, boundary select in pwm
// - bits 6:4 halve divisor per code step
// - mode bit7 runs or holds counter
// - event mode keeps pin irq flag zero
// - green wake enable gates overflow wake
// - fast select picks oscillator over instruction clock
// - event mode ignores fast select and prescaler
// - overflow sets sticky flag, software clears
// - overflow reloads count from reload: bit2 set without pwm, or pwm on event pin
// - boundary 256 outside narrowed pwm cases
// - pwm, reload off, buzzer on: 64
// - pwm, reload on, buzzer off: 32
// - pwm, reload and buzzer on: 16
// - one count per tick, full-scale wraps to zero
// - event mode counts falling pin edges
// - reload writes held until next overflow, passed on at once while stopped
// - pwm low at reload match, high at overflow
module tmz_timer0
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_pin_i,
    input wire logic green_mode_i,
    output logic pin_timer_sel_o,
    output logic pin_level_o,
    output logic overflow_flag_o,
    output logic event_pin_irq_flag_o,
    output logic green_wake_o
);
    // ***************************************************************
    // sub-blocks
    // ***************************************************************
    tmz_tick_if tick_bus();

    tmz_prescaler u_presc
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tick(tick_bus)
    );

    tmz_event_sync u_evt
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(event_pin_i),
        .evt(tick_bus)
    );

    // ***************************************************************
    // registers
    // ***************************************************************
    tmz_pkg::tmz_byte_t mode_q;
    tmz_pkg::tmz_byte_t clock_wake_q;
    tmz_pkg::tmz_byte_t count_q;
    tmz_pkg::tmz_byte_t count_d;
    tmz_pkg::tmz_byte_t reload_hold_q;
    tmz_pkg::tmz_byte_t reload_act_q;
    logic buz_level_q;
    logic pwm_level_q;
    tmz_pkg::tmz_byte_t rd_mux;

    // ***************************************************************
    // mode decode
    // ***************************************************************
    logic run_en;
    logic pwm_en;
    logic buz_bit;
    logic aload_bit;
    logic src_ext;
    logic buz_en;
    logic reload_en;
    logic pwm_active;

    assign run_en = mode_q[`TMZ_MODE_RUN];
    assign pwm_en = mode_q[`TMZ_MODE_PWM];
    assign buz_bit = mode_q[`TMZ_MODE_BUZ];
    assign aload_bit = mode_q[`TMZ_MODE_ALOAD];
    assign src_ext = mode_q[`TMZ_MODE_SRC];
    assign buz_en = buz_bit && !pwm_en;
    assign pwm_active = pwm_en && !src_ext;
    // pwm always reloads its duty; otherwise the reload bit decides
    assign reload_en = pwm_en ? 1'b1 : aload_bit;

    // prescaler steering; ignored entirely while counting events
    assign tick_bus.fast_sel = clock_wake_q[`TMZ_CW_FAST];
    assign tick_bus.rate = mode_q[`TMZ_MODE_RATE_HI:`TMZ_MODE_RATE_LO];

    // ***************************************************************
    // count tick and overflow boundary
    // ***************************************************************
    logic count_tick;
    tmz_pkg::tmz_byte_t bound_mask;
    logic at_full;
    logic overflow;
    tmz_pkg::tmz_byte_t count_inc;

    // external source uses pin edges only, never the prescaler
    assign count_tick = run_en && (src_ext ? tick_bus.event_fall : tick_bus.int_tick);

    // boundary: narrowed only in pwm with the internal clock
    assign bound_mask = !pwm_active ? `TMZ_MASK_256 :
                        (!aload_bit && !buz_bit) ? `TMZ_MASK_256 :
                        (!aload_bit && buz_bit) ? `TMZ_MASK_64 :
                        (aload_bit && !buz_bit) ? `TMZ_MASK_32 :
                        `TMZ_MASK_16;

    assign at_full = ((count_q & bound_mask) == bound_mask);
    assign overflow = count_tick && at_full;
    assign count_inc = count_q + 8'h01;

    // ***************************************************************
    // apb decode
    // ***************************************************************
    logic setup_ph;
    logic access_done;
    logic wr_done;
    logic [`TMZ_IDX_W-1:0] idx;
    logic addr_ok;
    logic sel_cw;
    logic sel_mode;
    logic sel_count;
    logic sel_reload;
    logic sel_status;

    assign setup_ph = psel && !penable;
    assign access_done = psel && penable && pready;
    assign idx = paddr[9:2];
    assign sel_cw = (idx == `TMZ_IDX_CLOCK_WAKE);
    assign sel_mode = (idx == `TMZ_IDX_MODE);
    assign sel_count = (idx == `TMZ_IDX_COUNT);
    assign sel_reload = (idx == `TMZ_IDX_RELOAD);
    assign sel_status = (idx == `TMZ_IDX_STATUS);
    assign addr_ok = (paddr[1:0] == 2'b00) && (sel_cw || sel_mode || sel_count || sel_reload || sel_status);
    assign wr_done = access_done && pwrite && addr_ok;

    // read mux; reload is write-only so it reads zero
    assign rd_mux = sel_cw ? clock_wake_q :
                    sel_mode ? mode_q :
                    sel_count ? count_q :
                    sel_status ? {6'h00, event_pin_irq_flag_o, overflow_flag_o} :
                    8'h00;

    // ***************************************************************
    // apb response: one-cycle access phase, no wait states
    // ***************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_ok; // unmapped or misaligned
            if (setup_ph)
            begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    // run enable lives in the same byte; software sets it last
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mode_q <= `TMZ_MODE_RESET;
            clock_wake_q <= `TMZ_CW_RESET;
        end
        else
        begin
            if (wr_done && sel_mode)
            begin
                mode_q <= pwdata[7:0];
            end
            if (wr_done && sel_cw)
            begin
                clock_wake_q <= {4'h0, pwdata[`TMZ_CW_OTHER:`TMZ_CW_GREEN], 1'b0};
            end
        end
    end

    // ***************************************************************
    // counter and reload double buffer
    // ***************************************************************
    // software write wins over a tick in the same cycle
    always_comb
    begin
        count_d = count_q;
        if (wr_done && sel_count)
        begin
            count_d = pwdata[7:0];
        end
        else if (overflow)
        begin
            if (pwm_active)
            begin
                count_d = 8'h00; // pwm period restarts, reload holds the duty
            end
            else if (reload_en)
            begin
                count_d = reload_hold_q;
            end
            else
            begin
                count_d = 8'h00;
            end
        end
        else if (count_tick)
        begin
            count_d = count_inc;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            count_q <= `TMZ_COUNT_RESET;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // new reload value waits in the hold buffer for an overflow, or passes on each cycle while stopped
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            reload_hold_q <= `TMZ_RELOAD_RESET;
            reload_act_q <= `TMZ_RELOAD_RESET;
        end
        else
        begin
            if (wr_done && sel_reload)
            begin
                reload_hold_q <= pwdata[7:0];
            end
            if (overflow || !run_en)
            begin
                reload_act_q <= reload_hold_q;
            end
        end
    end

    // ***************************************************************
    // status flags: hardware set beats software clear
    // ***************************************************************
    logic clr_ovf;
    logic clr_pin;
    logic pin_irq_set;

    // writing zero to a flag clears it, writing one leaves it
    assign clr_ovf = wr_done && sel_status && !pwdata[`TMZ_ST_OVF];
    assign clr_pin = wr_done && sel_status && !pwdata[`TMZ_ST_PIN_IRQ];
    assign pin_irq_set = tick_bus.event_fall && !src_ext;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            overflow_flag_o <= 1'b0;
            event_pin_irq_flag_o <= 1'b0;
        end
        else
        begin
            overflow_flag_o <= overflow || (overflow_flag_o && !clr_ovf);
            // event mode keeps the pin interrupt silent and the flag at zero
            event_pin_irq_flag_o <= !src_ext && (pin_irq_set || (event_pin_irq_flag_o && !clr_pin));
        end
    end

    // ***************************************************************
    // green mode wake and shared pin
    // ***************************************************************
    // wake is a one-cycle pulse; only asked for while in green mode
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            green_wake_o <= 1'b0;
        end
        else
        begin
            green_wake_o <= overflow && green_mode_i && clock_wake_q[`TMZ_CW_GREEN];
        end
    end

    // buzzer toggles on each overflow, so it runs at half the overflow rate
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            buz_level_q <= 1'b0;
        end
        else if (!buz_en)
        begin
            buz_level_q <= 1'b0;
        end
        else if (overflow)
        begin
            buz_level_q <= !buz_level_q;
        end
    end

    // pwm: high from overflow until the count meets the duty value
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            pwm_level_q <= 1'b1;
        end
        else if (!pwm_en || !run_en)
        begin
            pwm_level_q <= 1'b1;
        end
        else if (overflow)
        begin
            pwm_level_q <= 1'b1;
        end
        else if (count_tick && ((count_d & bound_mask) == (reload_act_q & bound_mask)))
        begin
            pwm_level_q <= 1'b0;
        end
    end

    // pin is general i/o unless pwm or buzzer owns it
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            pin_timer_sel_o <= 1'b0;
            pin_level_o <= 1'b0;
        end
        else
        begin
            pin_timer_sel_o <= pwm_en || buz_en;
            pin_level_o <= pwm_en ? (pwm_level_q || !run_en) : buz_level_q;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tmz_evt_src.sv
// external event source: bursts of falling edges on the event pin
// assumes: pin has a pull-up, so it idles high between bursts
`timescale 1ns/1ps
`default_nettype none
module tmz_evt_src
(
    input wire logic go_i,
    input wire logic [7:0] n_i,
    output logic pin_o,
    output logic done_o
);
    // edge spacing unrelated to the 20 ns clock
    initial
    begin
        pin_o = 1'h1;
        done_o = 1'h0;
        forever
        begin
            @(posedge go_i);
            done_o = 1'h0;
            repeat (n_i)
            begin
                #77 pin_o = 1'h0;
                #93 pin_o = 1'h1;
            end
            done_o = 1'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tmz_timer0_sva.sv
// port checker of timer 0: apb answers, sticky flags, pin selection, wake pulse
// assumes: bound to tmz_timer0, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0_sva
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pin_timer_sel_o,
    input wire logic pin_level_o,
    input wire logic overflow_flag_o,
    input wire logic event_pin_irq_flag_o,
    input wire logic green_wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ***************************************************************
    // shadow copies of mode and clock/wake
    // ***************************************************************
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] cw_q;
    logic [7:0] cw_d;
    logic wr_en;
    logic mapped;
    logic st_wr;
    assign wr_en = psel && penable && pready && pwrite;
    assign mode_d = (wr_en && paddr == 10'h368) ? pwdata[7:0] : mode_q;
    assign cw_d = (wr_en && paddr == 10'h360) ? pwdata[7:0] : cw_q;
    assign st_wr = psel && penable && pwrite && paddr == 10'h370;
    assign mapped = paddr inside {10'h360, 10'h368, 10'h36C, 10'h334, 10'h370};
    // shadows follow completed writes
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mode_q <= 8'h00;
            cw_q <= 8'h00;
        end
        else
        begin
            mode_q <= mode_d;
            cw_q <= cw_d;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ovf_rise;
        $rose(overflow_flag_o);
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    property p_err;
        pready |-> pslverr == !mapped;
    endproperty
    property p_upper;
        pready |-> prdata[31:8] == 24'h000000;
    endproperty
    property p_sticky;
        overflow_flag_o && !st_wr |=> overflow_flag_o;
    endproperty
    property p_irq_off;
        mode_q[3] && $past(mode_q[3]) |-> !event_pin_irq_flag_o;
    endproperty
    property p_pin_sel;
        $stable(mode_q) |-> pin_timer_sel_o == (mode_q[0] || mode_q[1]);
    endproperty
    property p_pwm_idle;
        $stable(mode_q) && mode_q[0] && !mode_q[7] |-> pin_level_o;
    endproperty
    property p_run;
        s_ovf_rise |-> $past(mode_q[7]) || $past(mode_q[7], 2);
    endproperty
    property p_wake_en;
        green_wake_o |-> cw_q[1] || $past(cw_q[1]);
    endproperty
    property p_wake_pulse;
        green_wake_o |=> !green_wake_o;
    endproperty
    a_ready: assert property (p_ready) else $error("no answer");
    a_err: assert property (p_err) else $error("bad slave error");
    a_upper: assert property (p_upper) else $error("upper bits set");
    a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
    a_irq_off: assert property (p_irq_off) else $error("pin irq in event mode");
    a_pin_sel: assert property (p_pin_sel) else $error("pin select");
    a_pwm_idle: assert property (p_pwm_idle) else $error("pwm low while stopped");
    a_run: assert property (p_run) else $error("overflow while stopped");
    a_wake_en: assert property (p_wake_en) else $error("wake while disabled");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
endmodule
bind tmz_timer0 tmz_timer0_sva u_sva (.clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_timer_sel_o, .pin_level_o, .overflow_flag_o, .event_pin_irq_flag_o, .green_wake_o);
`default_nettype wire

// >>> verification/tmz_timer0_tb_top.sv
// self-checking bench of timer 0
// assumes: package, interface and design compiled first; 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "tmz_defines.svh"
module tmz_timer0_tb_top;
    localparam a_cw = {`TMZ_IDX_CLOCK_WAKE, 2'h0};
    localparam a_md = {`TMZ_IDX_MODE, 2'h0};
    localparam a_ct = {`TMZ_IDX_COUNT, 2'h0};
    localparam a_rl = {`TMZ_IDX_RELOAD, 2'h0};
    localparam a_st = {`TMZ_IDX_STATUS, 2'h0};
    logic clk_i, rst_b_i, psel, penable, pwrite, green_mode_i, go, done, pin;
    logic pready, pslverr, sel, lvl, ovf, pirq, wake, err;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] n, rs, r;
    int fails = 0, compares = 0, wk = 0, wk0, hi, per, k, dv, bd;
    tmz_timer0 uut (.clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .event_pin_i(pin), .green_mode_i, .pin_timer_sel_o(sel), .pin_level_o(lvl),
        .overflow_flag_o(ovf), .event_pin_irq_flag_o(pirq), .green_wake_o(wake));
    tmz_evt_src u_evt (.go_i(go), .n_i(n), .pin_o(pin), .done_o(done));
    initial
    begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    // wake pulses counted: one cycle each
    always @(posedge clk_i)
    begin
        if (wake === 1'h1)
            wk <= wk + 1;
    end
    // ***************************************************************
    // functions and tasks
    // ***************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int pwm_bound(input int m);
        return (m == 3) ? 16 : (m == 2) ? 32 : (m == 1) ? 64 : 256;
    endfunction
    task automatic chk(input logic [31:0] got, lo, hv, input string m);
        compares++;
        if ((got >= lo && got <= hv) !== 1'h1)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic results;
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, after an idle edge
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int t = 0;
        @(posedge clk_i);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_i);
        penable <= 1'h1;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (pready !== 1'h1 && t < 20);
        if (t >= 20)
            fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] lo, hv, input string m);
        apb(1'h0, a, 8'h00);
        chk(rd, {24'h000000, lo}, {24'h000000, hv}, m);
    endtask
    task automatic pulse(input logic [7:0] c);
        int t = 0;
        n <= c;
        go <= 1'h1;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (done !== 1'h1 && t < 400);
        go <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask
    // watchdog: run takes under 40000 cycles
    initial
    begin
        #800000;
        fails++;
        results();
    end
    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        rst_b_i = 1'h0;
        {psel, penable, pwrite, green_mode_i, go} = 5'h00;
        paddr = 10'h000;
        pwdata = 32'h00000000;
        n = 8'h00;
        rs = 8'h09;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'h1;
        rdc(a_md, 8'h00, 8'h00, "mode reset");
        rdc(a_ct, 8'h00, 8'h00, "count reset");
        rdc(a_cw, 8'h00, 8'h00, "cw reset");
        rdc(a_st, 8'h00, 8'h00, "status reset");
        apb(1'h1, a_cw, 8'hFF);
        rdc(a_cw, 8'h0E, 8'h0E, "cw bits");
        rdc(a_rl, 8'h00, 8'h00, "reload write-only");
        apb(1'h0, 10'h3FC, 8'h00);
        chk(err, 1, 1, "unmapped error");
        apb(1'h1, a_md + 10'h001, 8'h80);
        rdc(a_md, 8'h00, 8'h00, "misaligned");
        rs = lfsr(rs);
        apb(1'h1, a_ct, rs);
        apb(1'h1, a_md, 8'h70);
        repeat (40) @(posedge clk_i);
        rdc(a_ct, rs, rs, "count held");
        // all fast rates, short slow rates: eight ticks each
        for (int i = 0; i < 12; i++)
        begin
            dv = (i < 8) ? (128 >> i) : (1024 >> (i - 4));
            apb(1'h1, a_md, {1'h0, 3'(i < 8 ? i : i - 4), 4'h0});
            apb(1'h1, a_cw, (i < 8) ? 8'h04 : 8'h00);
            apb(1'h1, a_ct, 8'h00);
            apb(1'h1, a_md, {1'h1, 3'(i < 8 ? i : i - 4), 4'h0});
            repeat (8 * dv) @(posedge clk_i);
            rdc(a_ct, 8'h07, (dv < 4) ? 8'h0B : 8'h09, "tick rate");
        end
        // overflow with auto-reload, buzzer and green wake
        rs = lfsr(rs);
        r = rs & 8'h70;
        green_mode_i <= 1'h1;
        apb(1'h1, a_md, 8'h00);
        apb(1'h1, a_cw, 8'h06);
        apb(1'h1, a_rl, r);
        apb(1'h1, a_ct, 8'hFE);
        wk0 = wk;
        apb(1'h1, a_md, 8'hF6);
        apb(1'h1, a_md, 8'h76);
        rdc(a_ct, r, r + 8'h04, "reloaded count");
        rdc(a_st, 8'h01, 8'h01, "overflow flag");
        chk(wk - wk0, 1, 1, "green wake");
        chk({sel, lvl, ovf, pirq}, 14, 14, "buzzer and flags");
        apb(1'h1, a_st, 8'h00);
        rdc(a_st, 8'h00, 8'h00, "flag cleared");
        apb(1'h1, a_cw, 8'h04);
        apb(1'h1, a_ct, 8'hFE);
        wk0 = wk;
        apb(1'h1, a_md, 8'hF0);
        apb(1'h1, a_md, 8'h70);
        rdc(a_ct, 8'h00, 8'h04, "wrap to zero");
        chk(wk - wk0, 0, 0, "wake disabled");
        chk(sel, 0, 0, "pin back to io");
        // pwm: each resolution, quarter duty
        for (int m = 0; m < 4; m++)
        begin
            bd = pwm_bound(m);
            apb(1'h1, a_md, {4'h7, 1'h0, 2'(m), 1'h1});
            apb(1'h1, a_ct, 8'h00);
            apb(1'h1, a_rl, 8'(bd / 4));
            apb(1'h1, a_md, {4'hF, 1'h0, 2'(m), 1'h1});
            for (k = 0; k < 600 && lvl !== 1'h0; k++) @(posedge clk_i);
            for (k = 0; k < 600 && lvl !== 1'h1; k++) @(posedge clk_i);
            for (hi = 0; hi < 600 && lvl === 1'h1; hi++) @(posedge clk_i);
            for (per = hi; per < 600 && lvl === 1'h0; per++) @(posedge clk_i);
            chk(per, bd, bd, "pwm period");
            chk(hi, bd / 4, bd / 4, "pwm high time");
            chk(sel, 1, 1, "pwm on pin");
            apb(1'h1, a_md, 8'h00);
        end
        // event pin: flagged as io, counted as source
        apb(1'h1, a_st, 8'h00);
        pulse(8'h03);
        rdc(a_st, 8'h02, 8'h02, "pin irq set");
        chk({ovf, pirq}, 1, 1, "flag pins");
        apb(1'h1, a_st, 8'h00);
        rs = lfsr(rs);
        apb(1'h1, a_ct, 8'h0E);
        apb(1'h1, a_md, 8'h7F);
        apb(1'h1, a_md, 8'hFF);
        pulse(8'h04 + (rs & 8'h07));
        rdc(a_ct, 8'h12 + (rs & 8'h07), 8'h12 + (rs & 8'h07), "event count");
        rdc(a_st, 8'h00, 8'h00, "irq suppressed");
        results();
    end
endmodule
`default_nettype wire
